// File: pwn_top.sv
// Purpose: Pad waveform generator control and pad event notification
// Assumes: Pad and trigger inputs already synchronous to ref_clk
// Notes: Register reads answer two cycles after the strobe
`timescale 1ns/1ns
`default_nettype none
`include "pwn_map.svh"

module pwn_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [15:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire pwn_pkg::pwn_byte_t reg_wdata,
    output pwn_pkg::pwn_byte_t reg_rdata,
    output logic reg_rvalid,
    input wire logic [11:0] pad_in,
    input wire logic frame_valid,
    input wire logic flash_strobe,
    output logic [7:0] wave_out,
    output logic [7:0] wave_oe,
    output logic wake_req
);
    import pwn_pkg::*;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic div_tick(input logic [15:0] pre, input logic [3:0] d);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (i <= int'(d) && !pre[i]) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    function automatic logic [5:0] sub_index(input logic [2:0] pad, input logic [2:0] sub);
        return 6'(6'(pad) * `PWN_SUBS_PER_PAD + 6'(sub));
    endfunction

    function automatic logic is_cnt_addr(input logic [15:0] a, input int pad);
        if (pad == 6) begin
            return a == `PWN_A_CNT_PAD6;
        end else if (pad == 7) begin
            return a == `PWN_A_CNT_PAD7;
        end
        return a == 16'(`PWN_A_CNT_LO_BASE + 16'(pad));
    endfunction

    // ----------------------------------------------------------------
    // Register file
    // ----------------------------------------------------------------
    logic [3:0] pair_en_r;
    logic [7:0] div_cfg_r, div_pick_r, frame_gate_r, halt_r, pause_r, src_pick_r;
    logic [7:0] pol_lo_r, blk_lo_r, flash_gate_r, flags_lo_r;
    logic [3:0] pol_hi_r, blk_hi_r, flags_hi_r;
    logic [7:0] per_cfg_r [0:7];
    logic [7:0] per_left_r [0:7];
    logic [7:0] cnt_wr;
    logic sub_wr, sub_rd;

    always_comb begin
        for (int p = 0; p < 8; p++) begin
            cnt_wr[p] = reg_wr && is_cnt_addr(reg_addr, p);
        end
    end
    assign sub_wr = reg_wr && reg_addr >= `PWN_A_SUB_BASE && reg_addr <= `PWN_A_SUB_LAST;
    assign sub_rd = reg_addr >= `PWN_A_SUB_BASE && reg_addr <= `PWN_A_SUB_LAST;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pair_en_r <= 4'h0;
            div_cfg_r <= `PWN_RST_BYTE;
            div_pick_r <= `PWN_RST_BYTE;
            frame_gate_r <= `PWN_RST_BYTE;
            halt_r <= `PWN_RST_BYTE;
            pause_r <= `PWN_RST_BYTE;
            src_pick_r <= `PWN_RST_BYTE;
            pol_lo_r <= `PWN_RST_BYTE;
            pol_hi_r <= 4'h0;
            blk_lo_r <= `PWN_RST_BLK_LO;
            blk_hi_r <= `PWN_RST_BLK_HI;
            flash_gate_r <= `PWN_RST_BYTE;
        end else if (reg_wr) begin
            case (reg_addr)
                `PWN_A_PAIR_EN: pair_en_r <= reg_wdata[3:0];
                `PWN_A_DIV_CFG: div_cfg_r <= reg_wdata;
                `PWN_A_DIV_PICK: div_pick_r <= reg_wdata;
                `PWN_A_FRAME_GATE: frame_gate_r <= reg_wdata;
                `PWN_A_HALT: halt_r <= reg_wdata;
                `PWN_A_PAUSE: pause_r <= reg_wdata;
                `PWN_A_SRC_PICK: src_pick_r <= reg_wdata;
                `PWN_A_POL_LO: pol_lo_r <= reg_wdata;
                `PWN_A_POL_HI: pol_hi_r <= reg_wdata[3:0];
                `PWN_A_BLK_LO: blk_lo_r <= reg_wdata;
                `PWN_A_BLK_HI: blk_hi_r <= reg_wdata[3:0];
                `PWN_A_FLASH_GATE: flash_gate_r <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < 8; p++) begin
            if (reset) begin
                per_cfg_r[p] <= `PWN_RST_BYTE;
            end else if (cnt_wr[p]) begin
                per_cfg_r[p] <= reg_wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Subperiod store and scanner
    // ----------------------------------------------------------------
    // One shared read port serves all pads in turn; a subperiod load
    // costs up to nine cycles, a price paid to keep the store small.
    logic [2:0] scan_r, scan_q_r, scan_idx_q_r;
    logic [2:0] idx_r [0:7];
    logic [7:0] mem_a_data, mem_b_data;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            scan_r <= 3'd0;
            scan_q_r <= 3'd0;
            scan_idx_q_r <= 3'd0;
        end else begin
            scan_r <= scan_r + 3'd1;
            scan_q_r <= scan_r;
            scan_idx_q_r <= idx_r[scan_r];
        end
    end

    pwn_sub_mem u_sub_mem (
        .ref_clk(ref_clk),
        .reset(reset),
        .wr_en(sub_wr),
        .wr_addr(6'(reg_addr - `PWN_A_SUB_BASE)),
        .wr_data(reg_wdata),
        .rd_a_addr(6'(reg_addr - `PWN_A_SUB_BASE)),
        .rd_a_data(mem_a_data),
        .rd_b_addr(sub_index(scan_r, idx_r[scan_r])),
        .rd_b_data(mem_b_data)
    );

    // ----------------------------------------------------------------
    // Dividers and start triggers
    // ----------------------------------------------------------------
    logic [15:0] pre_r;
    logic tick1, tick2, frame_q_r, flash_q_r, frame_fall, flash_rise;
    logic [7:0] pause_q_r, tick_sel, gated, trig, run_ok, hit, adv;
    pwn_state_e st_r [0:7];
    logic [7:0] cnt_r [0:7];
    logic [7:0] fin_r;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            pre_r <= 16'h0000;
            pause_q_r <= 8'h00;
        end else begin
            pre_r <= pre_r + 16'h0001;
            pause_q_r <= pause_r;
        end
        // Trigger history follows the pins through reset, so release brings no false edge
        frame_q_r <= frame_valid;
        flash_q_r <= flash_strobe;
    end

    assign tick1 = div_tick(pre_r, div_cfg_r[3:0]);
    assign tick2 = div_tick(pre_r, div_cfg_r[7:4]);
    assign frame_fall = frame_q_r && !frame_valid;
    assign flash_rise = flash_strobe && !flash_q_r;

    always_comb begin
        for (int p = 0; p < 8; p++) begin
            tick_sel[p] = div_pick_r[p] ? tick2 : tick1;
            gated[p] = frame_gate_r[p] || flash_gate_r[p];
            run_ok[p] = pair_en_r[p / 2] && !halt_r[p];
            // Gated pads start only on an edge; ungated ones from idle, or on unpause when done
            trig[p] = gated[p] ? ((frame_gate_r[p] && frame_fall) || (flash_gate_r[p] && flash_rise))
                               : (st_r[p] == PWN_IDLE || (st_r[p] == PWN_DONE && pause_q_r[p]));
            hit[p] = st_r[p] == PWN_LOAD && scan_q_r == 3'(p) && scan_idx_q_r == idx_r[p];
            adv[p] = (hit[p] && mem_b_data == 8'h00) || (st_r[p] == PWN_RUN && tick_sel[p] && cnt_r[p] == 8'd1);
        end
    end

    // ----------------------------------------------------------------
    // Per-pad waveform sequencer
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < 8; p++) begin
            fin_r[p] <= 1'b0;
            if (reset) begin
                st_r[p] <= PWN_IDLE;
                idx_r[p] <= 3'd0;
                cnt_r[p] <= 8'h00;
                per_left_r[p] <= 8'h00;
                wave_out[p] <= 1'b0;
            end else if (!run_ok[p]) begin
                st_r[p] <= PWN_IDLE;
                idx_r[p] <= 3'd0;
                cnt_r[p] <= 8'h00;
                per_left_r[p] <= per_cfg_r[p];
                wave_out[p] <= 1'b0;
            end else if (cnt_wr[p]) begin
                per_left_r[p] <= reg_wdata;
            end else if (!pause_r[p] && trig[p]) begin
                st_r[p] <= PWN_LOAD;
                idx_r[p] <= 3'd0;
                cnt_r[p] <= 8'h00;
                per_left_r[p] <= per_cfg_r[p];
                wave_out[p] <= 1'b0;
            end else if (!pause_r[p]) begin
                if (adv[p]) begin
                    if (idx_r[p] != `PWN_LAST_SUB) begin
                        idx_r[p] <= idx_r[p] + 3'd1;
                        st_r[p] <= PWN_LOAD;
                    end else if (per_cfg_r[p] != 8'h00 && per_left_r[p] <= 8'd1) begin
                        st_r[p] <= PWN_DONE;
                        per_left_r[p] <= 8'h00;
                        wave_out[p] <= 1'b0;
                        fin_r[p] <= 1'b1;
                    end else begin
                        if (per_cfg_r[p] != 8'h00) begin
                            per_left_r[p] <= per_left_r[p] - 8'd1;
                        end
                        idx_r[p] <= 3'd0;
                        st_r[p] <= PWN_LOAD;
                    end
                end else if (hit[p]) begin
                    cnt_r[p] <= mem_b_data;
                    wave_out[p] <= !idx_r[p][0];
                    st_r[p] <= PWN_RUN;
                end else if (st_r[p] == PWN_RUN && tick_sel[p]) begin
                    cnt_r[p] <= cnt_r[p] - 8'd1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        for (int p = 0; p < 8; p++) begin
            wave_oe[p] <= !reset && run_ok[p];
        end
    end

    // ----------------------------------------------------------------
    // Notification and wake-up
    // ----------------------------------------------------------------
    logic [11:0] pad_q_r, ev, pol;
    logic [7:0] clr_lo;
    logic [3:0] clr_hi;

    assign pol = {pol_hi_r, pol_lo_r};
    always_comb begin
        for (int p = 0; p < 12; p++) begin
            ev[p] = pol[p] ? (pad_in[p] && !pad_q_r[p]) : (!pad_in[p] && pad_q_r[p]);
            if (p < 8 && src_pick_r[p % 8]) begin
                ev[p] = fin_r[p % 8];
            end
        end
    end
    assign clr_lo = (reg_wr && reg_addr == `PWN_A_FLAGS_LO) ? reg_wdata : 8'h00;
    assign clr_hi = (reg_wr && reg_addr == `PWN_A_FLAGS_HI) ? reg_wdata[3:0] : 4'h0;

    always_ff @(posedge ref_clk) begin
        // Pad history follows the pins through reset, so release brings no false edge
        pad_q_r <= pad_in;
        if (reset) begin
            flags_lo_r <= 8'h00;
            flags_hi_r <= 4'h0;
            wake_req <= 1'b0;
        end else begin
            // A new event beats a clear in the same cycle
            flags_lo_r <= (flags_lo_r & ~clr_lo) | ev[7:0];
            flags_hi_r <= (flags_hi_r & ~clr_hi) | ev[11:8];
            wake_req <= |({flags_hi_r, flags_lo_r} & ~{blk_hi_r, blk_lo_r});
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    logic [7:0] rd_mux, hold_r;
    logic rd_q_r, mem_sel_q_r;

    always_comb begin
        rd_mux = 8'h00;
        case (reg_addr)
            `PWN_A_PAIR_EN: rd_mux = {4'h0, pair_en_r};
            `PWN_A_DIV_CFG: rd_mux = div_cfg_r;
            `PWN_A_DIV_PICK: rd_mux = div_pick_r;
            `PWN_A_FRAME_GATE: rd_mux = frame_gate_r;
            `PWN_A_HALT: rd_mux = halt_r;
            `PWN_A_PAUSE: rd_mux = pause_r;
            `PWN_A_SRC_PICK: rd_mux = src_pick_r;
            `PWN_A_POL_LO: rd_mux = pol_lo_r;
            `PWN_A_POL_HI: rd_mux = {4'h0, pol_hi_r};
            `PWN_A_BLK_LO: rd_mux = blk_lo_r;
            `PWN_A_BLK_HI: rd_mux = {4'h0, blk_hi_r};
            `PWN_A_FLASH_GATE: rd_mux = flash_gate_r;
            `PWN_A_FLAGS_LO: rd_mux = flags_lo_r;
            `PWN_A_FLAGS_HI: rd_mux = {4'h0, flags_hi_r};
            default: ;
        endcase
        for (int p = 0; p < 8; p++) begin
            if (is_cnt_addr(reg_addr, p)) begin
                rd_mux = per_left_r[p];
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            hold_r <= 8'h00;
            rd_q_r <= 1'b0;
            mem_sel_q_r <= 1'b0;
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            hold_r <= rd_mux;
            rd_q_r <= reg_rd;
            mem_sel_q_r <= sub_rd;
            reg_rdata <= rd_q_r ? (mem_sel_q_r ? mem_a_data : hold_r) : 8'h00;
            reg_rvalid <= rd_q_r;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_div_one_period;
        @(posedge ref_clk) disable iff (reset)
        (tick1 && $stable(div_cfg_r)) |=> !tick1;
    endproperty
    a_div_one_period: assert property (p_div_one_period) else $error("divider one ticked twice in a row");

    property p_div_two_nibble;
        @(posedge ref_clk) disable iff (reset)
        (div_cfg_r[7:4] == 4'h0) |-> (tick2 == pre_r[0]);
    endproperty
    a_div_two_nibble: assert property (p_div_two_nibble) else $error("divider two ignores high nibble");

    property p_pick_count;
        @(posedge ref_clk) disable iff (reset)
        (st_r[0] == PWN_RUN && run_ok[0] && !pause_r[0] && !trig[0] && !cnt_wr[0] && cnt_r[0] > 8'd1
         && (div_pick_r[0] ? tick2 : tick1)) |=> (cnt_r[0] == $past(cnt_r[0]) - 8'd1);
    endproperty
    a_pick_count: assert property (p_pick_count) else $error("pad 0 did not count on picked divider");

    property p_frame_start;
        @(posedge ref_clk) disable iff (reset)
        (frame_gate_r[0] && frame_fall && !pause_r[0] && run_ok[0] && !cnt_wr[0]) |=> (st_r[0] == PWN_LOAD && idx_r[0] == 3'd0);
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame edge did not restart pad 0");

    property p_flash_start;
        @(posedge ref_clk) disable iff (reset)
        (flash_gate_r[0] && flash_rise && !pause_r[0] && run_ok[0] && !cnt_wr[0]) |=> (st_r[0] == PWN_LOAD && idx_r[0] == 3'd0);
    endproperty
    a_flash_start: assert property (p_flash_start) else $error("flash edge did not restart pad 0");

    property p_halt_stops;
        @(posedge ref_clk) disable iff (reset)
        halt_r[0] |=> (st_r[0] == PWN_IDLE && cnt_r[0] == 8'h00 && !wave_out[0] && !wave_oe[0]);
    endproperty
    a_halt_stops: assert property (p_halt_stops) else $error("halt did not stop pad 0");

    property p_pause_freezes;
        @(posedge ref_clk) disable iff (reset)
        (pause_r[0] && run_ok[0]) |=> ($stable(cnt_r[0]) && $stable(idx_r[0]));
    endproperty
    a_pause_freezes: assert property (p_pause_freezes) else $error("paused pad 0 moved");

    property p_finish_flag;
        @(posedge ref_clk) disable iff (reset)
        (fin_r[0] && src_pick_r[0]) |=> flags_lo_r[0];
    endproperty
    a_finish_flag: assert property (p_finish_flag) else $error("finish did not set flag 0");

    property p_edge_flag_hi;
        @(posedge ref_clk) disable iff (reset)
        (pol_hi_r[0] && pad_in[8] && !pad_q_r[8]) |=> flags_hi_r[0];
    endproperty
    a_edge_flag_hi: assert property (p_edge_flag_hi) else $error("rising edge on pad 8 missed");

    property p_flag_sticky;
        @(posedge ref_clk) disable iff (reset)
        (flags_lo_r[0] && !clr_lo[0]) |=> flags_lo_r[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag 0 dropped without a clear");

    property p_wake;
        @(posedge ref_clk) disable iff (reset)
        (|({flags_hi_r, flags_lo_r} & ~{blk_hi_r, blk_lo_r})) |=> wake_req;
    endproperty
    a_wake: assert property (p_wake) else $error("unblocked flag did not wake");

    property p_wake_blocked;
        @(posedge ref_clk) disable iff (reset)
        (({flags_hi_r, flags_lo_r} & ~{blk_hi_r, blk_lo_r}) == 12'h000) |=> !wake_req;
    endproperty
    a_wake_blocked: assert property (p_wake_blocked) else $error("wake without unblocked flag");
endmodule
`default_nettype wire

// File: pwn_map.svh
// Purpose: Register offsets, reset values and field sizes of the pad waveform and notify block
// Assumes: Byte-wide registers at 16-bit addresses on the device register port
// Notes: Pulled in by the top module only
`ifndef PWN_MAP_SVH
`define PWN_MAP_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define PWN_A_SUB_BASE 16'h1080
`define PWN_A_SUB_LAST 16'h10a7
`define PWN_A_CNT_LO_BASE 16'h1078
`define PWN_A_CNT_PAD6 16'h10af
`define PWN_A_CNT_PAD7 16'h10ae
`define PWN_A_PAIR_EN 16'h10b0
`define PWN_A_DIV_CFG 16'h10b2
`define PWN_A_DIV_PICK 16'h10b3
`define PWN_A_FRAME_GATE 16'h10b4
`define PWN_A_HALT 16'h10b5
`define PWN_A_PAUSE 16'h10b6
`define PWN_A_SRC_PICK 16'h10b8
`define PWN_A_POL_HI 16'h10b9
`define PWN_A_POL_LO 16'h10ba
`define PWN_A_BLK_HI 16'h10bb
`define PWN_A_BLK_LO 16'h10bc
`define PWN_A_FLASH_GATE 16'h10bd
`define PWN_A_FLAGS_HI 16'h10be
`define PWN_A_FLAGS_LO 16'h10bf

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define PWN_RST_BYTE 8'h00
`define PWN_RST_BLK_HI 4'hf
`define PWN_RST_BLK_LO 8'hff
`define PWN_SUBS_PER_PAD 6'd5
`define PWN_LAST_SUB 3'd4
`define PWN_SUB_WORDS 40
`define PWN_PRE_W 16

`endif

// File: pwn_pkg.sv
// Purpose: Types shared by the pad waveform and notify block
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Offsets and counts live in pwn_map.svh
package pwn_pkg;
    typedef enum logic [1:0] {PWN_IDLE, PWN_LOAD, PWN_RUN, PWN_DONE} pwn_state_e;
    typedef logic [7:0] pwn_byte_t;
endpackage

// File: pwn_sub_mem.sv
// Purpose: Subperiod setting store, one write port and two registered read ports
// Assumes: Synchronous active-high reset clears every word
// Notes: Port a serves register reads, port b the waveform scanner
`timescale 1ns/1ns
`default_nettype none
module pwn_sub_mem (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic wr_en,
    input wire logic [5:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [5:0] rd_a_addr,
    output logic [7:0] rd_a_data,
    input wire logic [5:0] rd_b_addr,
    output logic [7:0] rd_b_data
);
    logic [7:0] mem_r [0:39];

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            for (int i = 0; i < 40; i++) begin
                mem_r[i] <= 8'h00;
            end
        end else if (wr_en && wr_addr < 6'd40) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rd_a_data <= 8'h00;
            rd_b_data <= 8'h00;
        end else begin
            rd_a_data <= (rd_a_addr < 6'd40) ? mem_r[rd_a_addr] : 8'h00;
            rd_b_data <= (rd_b_addr < 6'd40) ? mem_r[rd_b_addr] : 8'h00;
        end
    end
endmodule
`default_nettype wire

// File: pwn_pad_model.sv
// Purpose: Accessory side of the pads, driving pad levels and trigger lines
// Assumes: Levels change just after a rising edge of ref_clk
// Notes: Frame and flash lines idle low between one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
module pwn_pad_model (
    output logic [11:0] pad_in,
    output logic frame_valid,
    output logic flash_strobe,
    input wire logic ref_clk
);
    initial begin
        pad_in = 12'h001;
        frame_valid = 1'b0;
        flash_strobe = 1'b0;
    end
    // Any accessory may move any pad, input or output alike
    task automatic set_pads(input logic [11:0] v);
        @(posedge ref_clk);
        pad_in <= v;
    endtask
    // One-cycle high pulse on the frame line when frame is set, else on the flash line
    task automatic pulse(input logic frame);
        @(posedge ref_clk);
        frame_valid <= frame;
        flash_strobe <= !frame;
        @(posedge ref_clk);
        frame_valid <= 1'b0;
        flash_strobe <= 1'b0;
    endtask
endmodule
`default_nettype wire

// File: test_pad_waveform_and_notify.sv
// Purpose: Self-checking bench for the pad waveform and notify block
// Assumes: Register reads answer two cycles after the strobe
// Notes: Subperiod lengths checked as a window, prescaler phase is free
`timescale 1ns/1ns
`default_nettype none
module test_pad_waveform_and_notify;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, wave_out, wave_oe;
    logic reg_rvalid, wake_req, frame_valid, flash_strobe;
    logic [11:0] pad_in;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    always #2 ref_clk = ~ref_clk;
    pwn_top DUT (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pad_in(pad_in),
        .frame_valid(frame_valid), .flash_strobe(flash_strobe), .wave_out(wave_out), .wave_oe(wave_oe),
        .wake_req(wake_req));
    pwn_pad_model pads (.pad_in(pad_in), .frame_valid(frame_valid), .flash_strobe(flash_strobe),
        .ref_clk(ref_clk));
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk(what, exp, reg_rvalid === 1'b1 ? reg_rdata : 8'hzz);
    endtask
    // Window compare: tick phase at start is not pinned down
    task automatic high_len(input int lo, input int hi, input string what);
        int n;
        n = 0;
        while (wave_out[0] !== 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        n = 0;
        while (wave_out[0] === 1'b1 && n < 300) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        checks++;
        if (n < lo || n > hi) begin
            err_total++;
            $display("BAD %s expected %0d to %0d seen %0d", what, lo, hi, n);
        end
    endtask
    task automatic t_reset;
        rd(16'h10bc, 8'hff, "block_lo");
        rd(16'h10bb, 8'h0f, "block_hi");
        rd(16'h10bf, 8'h00, "flags_lo");
        $display("test reset values done");
    endtask
    task automatic t_edge;
        wr(16'h10b9, 8'h01);
        pads.set_pads(12'h100);
        repeat (3) @(posedge ref_clk);
        #1;
        chk("wake blocked", 8'h00, {7'h00, wake_req});
        rd(16'h10be, 8'h01, "flags_hi rise");
        rd(16'h10bf, 8'h01, "flags_lo fall");
        wr(16'h10bb, 8'h0e);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("wake open", 8'h01, {7'h00, wake_req});
        wr(16'h10be, 8'h01);
        wr(16'h10bf, 8'h01);
        rd(16'h10be, 8'h00, "flags_hi cleared");
        chk("wake gone", 8'h00, {7'h00, wake_req});
        $display("test pad edges done");
    endtask
    task automatic t_wave;
        wr(16'h1080, 8'h04);
        wr(16'h1081, 8'h02);
        wr(16'h1078, 8'h01);
        wr(16'h10b8, 8'h01);
        wr(16'h10b2, 8'h10);
        wr(16'h10b0, 8'h01);
        // Four ticks plus one scanner load gap of up to nine cycles
        high_len(8, 17, "divider one high");
        repeat (40) @(posedge ref_clk);
        rd(16'h10bf, 8'h01, "finish flag");
        rd(16'h1078, 8'h00, "periods left");
        chk("oe pair", 8'h03, wave_oe);
        wr(16'h10b3, 8'h01);
        wr(16'h10b5, 8'h01);
        repeat (2) @(posedge ref_clk);
        #1;
        chk("oe halted", 8'h02, wave_oe);
        wr(16'h1078, 8'h01);
        wr(16'h10b5, 8'h00);
        high_len(14, 25, "divider two high");
        $display("test waveform done");
    endtask
    task automatic t_gate;
        repeat (40) @(posedge ref_clk);
        wr(16'h10b6, 8'h01);
        wr(16'h10b4, 8'h01);
        wr(16'h10b6, 8'h00);
        repeat (12) @(posedge ref_clk);
        #1;
        chk("frame gate holds", 8'h00, {7'h00, wave_out[0]});
        pads.pulse(1'b1);
        high_len(14, 25, "frame start");
        repeat (40) @(posedge ref_clk);
        wr(16'h10bd, 8'h01);
        wr(16'h10b4, 8'h00);
        pads.pulse(1'b0);
        high_len(14, 25, "flash start");
        repeat (40) @(posedge ref_clk);
        wr(16'h10bd, 8'h00);
        wr(16'h10b6, 8'h01);
        wr(16'h10b6, 8'h00);
        high_len(14, 25, "unpause start");
        $display("test gating done");
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 4000) begin
            err_total++;
            $display("timeout");
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset();
        t_edge();
        t_wave();
        t_gate();
        wrap_up();
    end
endmodule
`default_nettype wire
